/* File: uecb_bank.sv */
// USB endpoint control bank: sixteen endpoint control registers plus stall interrupt.
// Assumes the protocol engine on the same clock presents an endpoint number and
// raises a one-cycle stall event; software uses the strobe port.
`timescale 1ns/10ps
`default_nettype none
module uecb_bank (
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        host_mode_i,
    input  wire logic [3:0]  ep_sel_i,
    input  wire logic        stall_evt_i,
    output logic             rx_allow_o,
    output logic             tx_allow_o,
    output logic             setup_allow_o,
    output logic             hshk_en_o,
    output logic             ls_direct_o,
    output logic             retry_en_o,
    output logic             irq_o
);
    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic is_ep_addr(input logic [7:0] a);
        is_ep_addr = (a[7:6] == uecb_pkg::EP_CTRL_BASE[7:6]) && (a[1:0] == 2'b00);
    endfunction

    logic [7:0]  ctrl_r [uecb_pkg::EP_COUNT];
    logic [15:0] irq_stat_r;
    logic [15:0] irq_mask_r;
    logic [3:0]  wr_idx;
    logic [7:0]  sel_ctrl;

    assign wr_idx = addr_i[5:2];

    // ------------------------------------------------------------------
    // Endpoint control registers
    // ------------------------------------------------------------------
    // Stall flag is set by hardware and written by software; the event wins
    // so a stall arriving with a software clear is never lost.
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < uecb_pkg::EP_COUNT; i++) begin
            if (srst_i) begin
                ctrl_r[i] <= uecb_pkg::EP_CTRL_RESET;
            end else begin
                if (wr_i && is_ep_addr(addr_i) && (wr_idx == i[3:0])) begin
                    ctrl_r[i] <= wdata_i[7:0] & uecb_pkg::EP_CTRL_WMASK;
                end
                if (stall_evt_i && (ep_sel_i == i[3:0])) begin
                    ctrl_r[i][uecb_pkg::EP_STALLED_FLAG_BIT] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_stat_r <= uecb_pkg::IRQ_RESET;
        end else begin
            irq_stat_r <= (irq_stat_r
                & ~((wr_i && addr_i == uecb_pkg::IRQ_STATUS_OFS) ? wdata_i[15:0] : 16'h0000))
                | (stall_evt_i ? (16'h0001 << ep_sel_i) : 16'h0000);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_mask_r <= uecb_pkg::IRQ_RESET;
        end else if (wr_i && addr_i == uecb_pkg::IRQ_MASK_OFS) begin
            irq_mask_r <= wdata_i[15:0];
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            if (is_ep_addr(addr_i)) begin
                rdata_o <= {24'h00_0000, ctrl_r[wr_idx]};
            end else if (addr_i == uecb_pkg::IRQ_STATUS_OFS) begin
                rdata_o <= {16'h0000, irq_stat_r};
            end else if (addr_i == uecb_pkg::IRQ_MASK_OFS) begin
                rdata_o <= {16'h0000, irq_mask_r};
            end else begin
                rdata_o <= 32'h0000_0000;
            end
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Permissions for the selected endpoint
    // ------------------------------------------------------------------
    assign sel_ctrl = ctrl_r[ep_sel_i];

    uecb_ep_decode u_dec (
        .ctrl_i        (sel_ctrl),
        .is_ep0_i      (ep_sel_i == 4'h0),
        .host_mode_i   (host_mode_i),
        .rx_allow_o    (rx_allow_o),
        .tx_allow_o    (tx_allow_o),
        .setup_allow_o (setup_allow_o),
        .hshk_en_o     (hshk_en_o),
        .ls_direct_o   (ls_direct_o),
        .retry_en_o    (retry_en_o)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    reset_clear_a: assert property (@(posedge sys_clk_i) srst_i |=> (ctrl_r[0] == 8'h00) && !irq_o)
        else $error("control not cleared by reset");
    ep_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        wr_i && is_ep_addr(addr_i) && !stall_evt_i |=> ctrl_r[$past(wr_idx)] == ($past(wdata_i[7:0]) & 8'hdd))
        else $error("endpoint write not stored");
    unimpl_zero_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        rd_i && is_ep_addr(addr_i) |=> rdata_o[31:8] == 24'h00_0000 && !rdata_o[5])
        else $error("unimplemented bits read nonzero");
    stall_sets_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        stall_evt_i |=> ctrl_r[$past(ep_sel_i)][1] && irq_stat_r[$past(ep_sel_i)])
        else $error("stall event not recorded");
    setup_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        setup_allow_o |-> rx_allow_o && tx_allow_o && !sel_ctrl[4])
        else $error("setup allowed illegally");
    setup_ignored_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !(sel_ctrl[2] && sel_ctrl[3]) |-> !setup_allow_o)
        else $error("setup on half endpoint");
    rx_tx_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        rx_allow_o == sel_ctrl[3] && tx_allow_o == sel_ctrl[2])
        else $error("rx or tx permission wrong");
    host_ep0_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (ls_direct_o || retry_en_o) |-> host_mode_i && ep_sel_i == 4'h0)
        else $error("host bits used off endpoint 0");
    retry_dis_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        sel_ctrl[6] |-> !retry_en_o)
        else $error("retry despite disable");
    hshk_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        hshk_en_o == sel_ctrl[0])
        else $error("handshake enable wrong");
    irq_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        wr_i && addr_i == uecb_pkg::IRQ_STATUS_OFS && !stall_evt_i
        |=> (irq_stat_r & $past(wdata_i[15:0])) == 16'h0000)
        else $error("status bit not cleared by write of one");

    // ------------------------------------------------------------------
    // Checks on the register port
    // ------------------------------------------------------------------
    // Read data are a snapshot taken at the strobe, so a write in the same
    // cycle as a read must not leak into the returned word.
    rd_ep_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        rd_i && is_ep_addr(addr_i)
        |=> rdata_o[7:0] == $past(ctrl_r[wr_idx]))
        else $error("endpoint read returned wrong byte");
    rd_status_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        rd_i && addr_i == uecb_pkg::IRQ_STATUS_OFS
        |=> rdata_o == {16'h0000, $past(irq_stat_r)})
        else $error("status read returned wrong word");
    rd_mask_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        rd_i && addr_i == uecb_pkg::IRQ_MASK_OFS
        |=> rdata_o == {16'h0000, $past(irq_mask_r)})
        else $error("mask read returned wrong word");
    rd_unmapped_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        rd_i && !is_ep_addr(addr_i) && addr_i != uecb_pkg::IRQ_STATUS_OFS
            && addr_i != uecb_pkg::IRQ_MASK_OFS
        |=> rdata_o == 32'h0000_0000)
        else $error("unmapped read returned nonzero");
    // The read bus idles at zero so that a master sampling one cycle late
    // sees nothing stale.
    rd_idle_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !rd_i
        |=> rdata_o == 32'h0000_0000)
        else $error("read data outside read slot");
    mask_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        wr_i && addr_i == uecb_pkg::IRQ_MASK_OFS
        |=> irq_mask_r == $past(wdata_i[15:0]))
        else $error("mask write not stored");
    mask_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !(wr_i && addr_i == uecb_pkg::IRQ_MASK_OFS)
        |=> $stable(irq_mask_r))
        else $error("mask changed without write");
    reset_all_a: assert property (@(posedge sys_clk_i)
        srst_i
        |=> irq_stat_r == uecb_pkg::IRQ_RESET && irq_mask_r == uecb_pkg::IRQ_RESET
            && rdata_o == 32'h0000_0000 && sel_ctrl == uecb_pkg::EP_CTRL_RESET)
        else $error("state not cleared by reset");

    // ------------------------------------------------------------------
    // Checks on the endpoint registers
    // ------------------------------------------------------------------
    ep_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !(wr_i && is_ep_addr(addr_i)) && !stall_evt_i
        |=> ctrl_r[$past(wr_idx)] == $past(ctrl_r[wr_idx]))
        else $error("endpoint changed without cause");
    ep_other_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        wr_i && is_ep_addr(addr_i) && (wr_idx != ep_sel_i) && !stall_evt_i
        |=> !$stable(ep_sel_i) || (sel_ctrl == $past(sel_ctrl)))
        else $error("write leaked into another endpoint");
    bit5_zero_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !sel_ctrl[5])
        else $error("unimplemented endpoint bit set");
    // Software can only clear the stall flag; only the engine may raise it.
    stall_cause_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !stall_evt_i
        |=> !(ctrl_r[$past(ep_sel_i)][1] && !$past(ctrl_r[ep_sel_i][1])))
        else $error("stall flag set without stall");

    // ------------------------------------------------------------------
    // Checks on interrupt status and decoded permissions
    // ------------------------------------------------------------------
    irq_sticky_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !(wr_i && addr_i == uecb_pkg::IRQ_STATUS_OFS)
        |=> (irq_stat_r & $past(irq_stat_r)) == $past(irq_stat_r))
        else $error("status bit lost without clear");
    irq_cause_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !stall_evt_i
        |=> (irq_stat_r & ~$past(irq_stat_r)) == 16'h0000)
        else $error("status bit set without stall");
    setup_on_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        sel_ctrl[3] && sel_ctrl[2] && !sel_ctrl[4]
        |-> setup_allow_o)
        else $error("setup refused on control endpoint");
    retry_on_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        host_mode_i && ep_sel_i == 4'h0 && !sel_ctrl[6]
        |-> retry_en_o)
        else $error("retry missing on host endpoint 0");
    ls_direct_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        ls_direct_o == (host_mode_i && ep_sel_i == 4'h0 && sel_ctrl[7]))
        else $error("low speed direct wrong");

    stall_cov: cover property (@(posedge sys_clk_i) disable iff (srst_i) stall_evt_i ##1 irq_o);
    setup_cov: cover property (@(posedge sys_clk_i) disable iff (srst_i) setup_allow_o);
    ls_cov: cover property (@(posedge sys_clk_i) disable iff (srst_i) ls_direct_o && retry_en_o);
    clear_cov: cover property (@(posedge sys_clk_i) disable iff (srst_i) irq_o ##1 !irq_o);
    stall_rd_cov: cover property (@(posedge sys_clk_i) disable iff (srst_i) rd_i ##1 rdata_o[1]);
endmodule
`default_nettype wire

/* File: uecb_pkg.sv */
// Package for the USB endpoint control bank: register map, field positions and reset values.
// Assumes a single 10 MHz clock domain and a plain strobe register port.
// Function
// - There are sixteen endpoint control registers, one per endpoint 0 to 15, each acting alone.
// - Low-speed direct set on endpoint 0 in host mode talks straight to a low-speed device, clear uses a hub with preamble.
// - Retry-disable clear on endpoint 0 in host mode re-issues NACKed transactions, set stops retries.
// - With transmit and receive both on, control-disable set rejects SETUP and clear accepts it.
// - Control-disable has no effect unless transmit and receive are both enabled.
// - Receive-enable set lets the endpoint accept data, clear blocks reception.
// - Transmit-enable set lets the endpoint send data, clear blocks transmission.
// - The stall flag reads one once the endpoint has been stalled, until software next writes that control register, and zero otherwise.
// - Handshake-enable set exchanges handshakes, clear omits them for isochronous use.
// - Bits 31 to 8 and bit 5 read as zero and ignore writes.
package uecb_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int unsigned EP_COUNT = 16;
    localparam int unsigned EP_IDX_W = 4;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] EP_CTRL_BASE   = 8'h00;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h40;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h44;

    // ------------------------------------------------------------------
    // Endpoint control fields
    // ------------------------------------------------------------------
    localparam int unsigned LOW_SPEED_DIRECT_EN_BIT  = 7;
    localparam int unsigned NACK_RETRY_DISABLE_BIT   = 6;
    localparam int unsigned CONTROL_XFER_DISABLE_BIT = 4;
    localparam int unsigned EP_RECEIVE_EN_BIT        = 3;
    localparam int unsigned EP_TRANSMIT_EN_BIT       = 2;
    localparam int unsigned EP_STALLED_FLAG_BIT      = 1;
    localparam int unsigned EP_HANDSHAKE_EN_BIT      = 0;
    localparam logic [7:0]  EP_CTRL_WMASK            = 8'hdd;
    localparam logic [7:0]  EP0_HOST_MASK            = 8'hc0;
    localparam logic [7:0]  EP_CTRL_RESET            = 8'h00;

    // ------------------------------------------------------------------
    // Interrupt status: bit n is stall event on endpoint n
    // ------------------------------------------------------------------
    localparam logic [15:0] IRQ_RESET = 16'h0000;

endpackage

/* File: uecb_ep_decode.sv */
// One endpoint's permission decoder.
// Assumes its control byte comes from the register bank on the same clock.
`timescale 1ns/10ps
`default_nettype none
module uecb_ep_decode (
    input  wire logic [7:0] ctrl_i,
    input  wire logic       is_ep0_i,
    input  wire logic       host_mode_i,
    output logic            rx_allow_o,
    output logic            tx_allow_o,
    output logic            setup_allow_o,
    output logic            hshk_en_o,
    output logic            ls_direct_o,
    output logic            retry_en_o
);
    logic rx_en;
    logic tx_en;
    logic host_ep0;

    assign rx_en         = ctrl_i[uecb_pkg::EP_RECEIVE_EN_BIT];
    assign tx_en         = ctrl_i[uecb_pkg::EP_TRANSMIT_EN_BIT];
    assign rx_allow_o    = rx_en;
    assign tx_allow_o    = tx_en;
    // SETUP needs a bidirectional endpoint; the disable bit counts only then.
    assign setup_allow_o = rx_en & tx_en & ~ctrl_i[uecb_pkg::CONTROL_XFER_DISABLE_BIT];
    assign hshk_en_o     = ctrl_i[uecb_pkg::EP_HANDSHAKE_EN_BIT];
    assign host_ep0      = is_ep0_i & host_mode_i;
    assign ls_direct_o   = host_ep0 & ctrl_i[uecb_pkg::LOW_SPEED_DIRECT_EN_BIT];
    assign retry_en_o    = host_ep0 & ~ctrl_i[uecb_pkg::NACK_RETRY_DISABLE_BIT];
endmodule
`default_nettype wire

/* File: uecb_engine_model.sv */
// Stand-in for the protocol engine: endpoint select, host role and stall pulses.
// Assumes the bench raises a stall request for exactly one clock cycle.
`timescale 1ns/10ps
`default_nettype none
module uecb_engine_model (
    input  wire logic       sys_clk_i,
    input  wire logic [3:0] ep_req_i,
    input  wire logic       host_req_i,
    input  wire logic       stall_req_i,
    output logic      [3:0] ep_sel_o,
    output logic            host_mode_o,
    output logic            stall_evt_o
);
    // Registered like a real engine, so the bank sees its inputs one cycle late.
    always_ff @(posedge sys_clk_i) begin
        ep_sel_o    <= ep_req_i;
        host_mode_o <= host_req_i;
        stall_evt_o <= stall_req_i;
    end
endmodule
`default_nettype wire

/* File: uecb_bank_tb.sv */
// Self-checking bench for the endpoint control bank.
// Assumes the package, the design files and the engine model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module uecb_bank_tb;
    logic        sys_clk_i, srst_i, wr_i, rd_i, irq_o, rd_pend, h;
    logic        host_req, stall_req, host_mode, stall_evt, rx, tx, su, hs, ls, rt;
    logic [3:0]  ep_req, ep_sel, e;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, v, r, vals[16], exp_q[$];
    int          bad_count, n_checks, seed, i;

    uecb_engine_model i_eng (.sys_clk_i(sys_clk_i), .ep_req_i(ep_req), .host_req_i(host_req),
        .stall_req_i(stall_req), .ep_sel_o(ep_sel), .host_mode_o(host_mode),
        .stall_evt_o(stall_evt));
    uecb_bank i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .host_mode_i(host_mode), .ep_sel_i(ep_sel), .stall_evt_i(stall_evt),
        .rx_allow_o(rx), .tx_allow_o(tx), .setup_allow_o(su), .hshk_en_o(hs),
        .ls_direct_o(ls), .retry_en_o(rt), .irq_o(irq_o));

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Register port master and read-data monitor
    // ------------------------------------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        exp_q.push_back(exp);
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample exactly there.
    always @(posedge sys_clk_i) begin
        if (rd_pend === 1'b1) check("rdata", rdata_o, exp_q.pop_front());
        rd_pend <= rd_i;
    end

    // Arguments are copied at the call, so callers wait for the falling edge first.
    task automatic out_chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check(name, seen, exp);
    endtask

    initial begin
        repeat (3000) @(posedge sys_clk_i);
        bad_count++;
        complete_run();
    end

    initial begin
        seed = 72;
        {srst_i, wr_i, rd_i, host_req, stall_req, rd_pend} = 6'b100000;
        {addr_i, wdata_i, ep_req, bad_count, n_checks} = '0;
        repeat (16) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        for (i = 0; i < 16; i++) reg_rd(8'(4 * i), 32'h0000_0000);
        @(negedge sys_clk_i);
        out_chk("perm", {rx, tx, su, hs, ls, rt, irq_o}, 32'h0000_0000);
        for (i = 0; i < 16; i++) begin
            vals[i] = $random(seed) & 32'hffff_fffd;
            reg_wr(8'(4 * i), vals[i]);
        end
        for (i = 0; i < 16; i++) reg_rd(8'(4 * i), vals[i] & 32'h0000_00dd);
        reg_wr(8'h48, 32'hffff_ffff);
        reg_rd(8'h48, 32'h0000_0000);
        for (i = 0; i < 48; i++) begin
            r = $random(seed);
            v = r & 32'h0000_00dd;
            h = r[9];
            e = r[10] ? 4'h0 : 4'h9;
            ep_req   <= e;
            host_req <= h;
            reg_wr({2'b00, e, 2'b00}, v);
            @(negedge sys_clk_i);
            out_chk("perm", {rx, tx, su, hs, ls, rt}, {v[3], v[2], v[3] & v[2] & ~v[4], v[0],
                h && e == 4'h0 && v[7], h && e == 4'h0 && !v[6]});
        end
        ep_req    <= 4'h5;
        stall_req <= 1'b1;
        @(posedge sys_clk_i);
        stall_req <= 1'b0;
        reg_rd(8'h14, (vals[5] & 32'h0000_00dd) | 32'h0000_0002);
        reg_rd(8'h40, 32'h0000_0020);
        @(negedge sys_clk_i);
        out_chk("irq", irq_o, 32'h0000_0000);
        reg_wr(8'h44, 32'h0000_0020);
        @(negedge sys_clk_i);
        out_chk("irq", irq_o, 32'h0000_0001);
        reg_wr(8'h40, 32'h0000_0020);
        @(negedge sys_clk_i);
        out_chk("irq", irq_o, 32'h0000_0000);
        reg_wr(8'h14, 32'h0000_0000);
        reg_rd(8'h14, 32'h0000_0000);
        reg_rd(8'h40, 32'h0000_0000);
        // A second reset in mid-run must wipe a configured endpoint and the mask.
        reg_wr(8'h24, 32'h0000_00dd);
        srst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        reg_rd(8'h24, 32'h0000_0000);
        reg_rd(8'h44, 32'h0000_0000);
        repeat (3) @(posedge sys_clk_i);
        complete_run();
    end
endmodule
`default_nettype wire
